// ---- verilog/asis_top.sv ----
// Sequence input select register with APB slave and step routing.
// Assumes APB3 master on pclk and a sequencer on the same clock.
//
// Operation
// - Bits 1:0 pick the input for step one; reset to zero.
// - Bits 5:4 pick the input for step two.
// - Bits 9:8 pick the input for step three.
// - Bits 13:12 pick the input for step four.
// - Bits 17:16 pick the input for step five.
// - Bits 25:24 pick the input for step seven.
// - Bits 29:28 pick the input for step eight.
// - Field value n routes analog input n to the converter.
// - Two-bit gaps between fields are read-only and read zero.
`timescale 1ns/1ps
`include "asis_regs.svh"
module asis_top
  import asis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire asis_apb_req_type apb_req,
  output asis_apb_rsp_type apb_rsp,
  input wire logic step_req_vld,
  input wire asis_step_type step_req_idx,
  output asis_conv_type conv
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    asis_sel_type sel;
    asis_apb_rsp_type rsp;
    logic [15:0] cnt;
  } asis_top_st_type;

  asis_top_st_type st_ff;
  asis_top_st_type nxt_st;
  logic [31:0] rd_word;
  logic [31:0] stat_word;
  logic setup;
  logic acc;
  logic hit_sel;
  logic hit_stat;
  logic wr_done;

  // ****************************************
  // Field placement
  // ****************************************
  // Used for both write decode and read packing
  function automatic logic [4:0] fld_lsb(input asis_step_type i);
    case (i)
      3'h0: fld_lsb = `ASIS_STEP1_LSB;
      3'h1: fld_lsb = `ASIS_STEP2_LSB;
      3'h2: fld_lsb = `ASIS_STEP3_LSB;
      3'h3: fld_lsb = `ASIS_STEP4_LSB;
      3'h4: fld_lsb = `ASIS_STEP5_LSB;
      3'h5: fld_lsb = `ASIS_STEP6_LSB;
      3'h6: fld_lsb = `ASIS_STEP7_LSB;
      3'h7: fld_lsb = `ASIS_STEP8_LSB;
      default: fld_lsb = `ASIS_STEP1_LSB;
    endcase
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  assign setup = apb_req.psel && !apb_req.penable;
  assign acc = apb_req.psel && apb_req.penable && st_ff.rsp.pready;
  assign hit_sel = apb_req.paddr == `ASIS_SEL_OFS;
  assign hit_stat = apb_req.paddr == `ASIS_STAT_OFS;
  assign wr_done = ce && acc && apb_req.pwrite && hit_sel;

  // ****************************************
  // Read words
  // ****************************************
  // Gap bits are never driven, so they read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      rd_word[fld_lsb(3'(i)) +: `ASIS_FIELD_W] = st_ff.sel[i];
    end
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`ASIS_STAT_STEP_LSB +: 3] = conv.step;
    stat_word[`ASIS_STAT_CHAN_LSB +: 2] = conv.chan;
    stat_word[`ASIS_STAT_VLD_BIT] = conv.vld;
    stat_word[`ASIS_STAT_CNT_LSB +: 16] = st_ff.cnt;
  end

  // ****************************************
  // Next state
  // ****************************************
  // Zero-wait slave: answer is prepared during setup so that pready
  // comes from a flop without adding a wait state.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.pready = setup;
    nxt_st.rsp.pslverr = 1'b0;
    if (setup) begin
      nxt_st.rsp.pslverr = !(hit_sel || hit_stat);
      nxt_st.rsp.prdata = 32'h0000_0000;
      if (!apb_req.pwrite && hit_sel) begin
        nxt_st.rsp.prdata = rd_word;
      end else if (!apb_req.pwrite && hit_stat) begin
        nxt_st.rsp.prdata = stat_word;
      end
    end
    // Only field bits are stored; gap bits of the write are dropped
    if (acc && apb_req.pwrite && hit_sel) begin
      for (int i = 0; i < 8; i++) begin
        nxt_st.sel[i] = apb_req.pwdata[fld_lsb(3'(i)) +: `ASIS_FIELD_W];
      end
    end
    // Wraps silently; a limitation for very long runs
    if (conv.vld) begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign apb_rsp = st_ff.rsp;

  // ****************************************
  // Step routing
  // ****************************************
  asis_step_mux u_step_mux (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sel(st_ff.sel),
    .req_vld(step_req_vld),
    .req_idx(step_req_idx),
    .conv(conv)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_step1;
    wr_done |=> rd_word[1:0] == $past(apb_req.pwdata[1:0]);
  endproperty
  a_step1: assert property (p_step1)
    else $error("step one field not stored");

  property p_step2;
    wr_done |=> rd_word[5:4] == $past(apb_req.pwdata[5:4]);
  endproperty
  a_step2: assert property (p_step2)
    else $error("step two field not stored");

  property p_step3;
    wr_done |=> rd_word[9:8] == $past(apb_req.pwdata[9:8]);
  endproperty
  a_step3: assert property (p_step3)
    else $error("step three field not stored");

  property p_step4;
    wr_done |=> rd_word[13:12] == $past(apb_req.pwdata[13:12]);
  endproperty
  a_step4: assert property (p_step4)
    else $error("step four field not stored");

  property p_step5;
    wr_done |=> rd_word[17:16] == $past(apb_req.pwdata[17:16]);
  endproperty
  a_step5: assert property (p_step5)
    else $error("step five field not stored");

  property p_step6;
    wr_done |=> rd_word[21:20] == $past(apb_req.pwdata[21:20]);
  endproperty
  a_step6: assert property (p_step6)
    else $error("step six field not stored");

  property p_step7;
    wr_done |=> rd_word[25:24] == $past(apb_req.pwdata[25:24]);
  endproperty
  a_step7: assert property (p_step7)
    else $error("step seven field not stored");

  property p_step8;
    wr_done |=> rd_word[29:28] == $past(apb_req.pwdata[29:28]);
  endproperty
  a_step8: assert property (p_step8)
    else $error("step eight field not stored");

  sequence s_sel_read;
    ce && setup && !apb_req.pwrite && hit_sel;
  endsequence

  property p_resv;
    s_sel_read |=> apb_rsp.pready
      && (apb_rsp.prdata & `ASIS_RESV_MASK) == 32'h0000_0000
      && apb_rsp.prdata == rd_word;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits read non-zero");

  property p_route_step1;
    (ce && step_req_vld && step_req_idx == 3'h0)
      |=> conv.chan == $past(rd_word[1:0]);
  endproperty
  a_route_step1: assert property (p_route_step1)
    else $error("step one does not route its field");

  property p_one_wait;
    (ce && setup) |=> apb_rsp.pready
      ##1 (!$past(ce) || !apb_rsp.pready);
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("pready not a single cycle after setup");

endmodule

// ---- verilog/asis_regs.svh ----
// Register offsets, field positions, reset values and masks for the
// sequence input select block. Assumes inclusion by bare name.
`ifndef ASIS_REGS_SVH
`define ASIS_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ASIS_SEL_OFS 12'h000
`define ASIS_STAT_OFS 12'h004

// ****************************************
// Selection field positions
// ****************************************
`define ASIS_FIELD_W 2
`define ASIS_STEP1_LSB 5'h00
`define ASIS_STEP2_LSB 5'h04
`define ASIS_STEP3_LSB 5'h08
`define ASIS_STEP4_LSB 5'h0c
`define ASIS_STEP5_LSB 5'h10
`define ASIS_STEP6_LSB 5'h14
`define ASIS_STEP7_LSB 5'h18
`define ASIS_STEP8_LSB 5'h1c

// ****************************************
// Reset values and masks
// ****************************************
`define ASIS_SEL_RST 2'h0
`define ASIS_RESV_MASK 32'hcccc_cccc

// ****************************************
// Status register layout
// ****************************************
`define ASIS_STAT_STEP_LSB 0
`define ASIS_STAT_CHAN_LSB 4
`define ASIS_STAT_VLD_BIT 8
`define ASIS_STAT_CNT_LSB 16

`endif

// ---- verilog/asis_pkg.sv ----
// Types shared by the sequence input select block.
// Assumes a single clock domain and an APB3 register bus.
package asis_pkg;

  // ****************************************
  // Selection types
  // ****************************************
  typedef logic [1:0] asis_chan_type;
  typedef asis_chan_type [7:0] asis_sel_type;
  typedef logic [2:0] asis_step_type;

  // ****************************************
  // Bus carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } asis_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } asis_apb_rsp_type;

  // ****************************************
  // Converter request carrier
  // ****************************************
  typedef struct packed {
    logic vld;
    asis_step_type step;
    asis_chan_type chan;
  } asis_conv_type;

endpackage

// ---- verilog/asis_step_mux.sv ----
// Per-step analog input routing for the sequencer.
// Assumes step requests come from logic on pclk, no synchroniser needed.
`timescale 1ns/1ps
module asis_step_mux
  import asis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire asis_sel_type sel,
  input wire logic req_vld,
  input wire asis_step_type req_idx,
  output asis_conv_type conv
);

  // ****************************************
  // State
  // ****************************************
  asis_conv_type st_ff;
  asis_conv_type nxt_st;
  asis_chan_type pick;

  // Field value is the channel number itself, no remapping
  assign pick = sel[req_idx];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.vld = req_vld;
    if (req_vld) begin
      nxt_st.step = req_idx;
      nxt_st.chan = pick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign conv = st_ff;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_req;
    ce && req_vld;
  endsequence

  property p_route;
    @(posedge pclk) disable iff (!presetn)
    s_req |=> conv.vld && conv.chan == $past(pick)
      && conv.step == $past(req_idx);
  endproperty
  a_route: assert property (p_route)
    else $error("converter channel does not follow step field");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(conv);
  endproperty
  a_hold: assert property (p_hold)
    else $error("converter request moved while frozen");

endmodule

// ---- verification/asis_top_tb.sv ----
// Self-checking bench for the sequence input select block.
// Assumes an APB slave with a one-cycle answer and registered outputs.
`timescale 1ns/1ps
`include "asis_regs.svh"
module asis_top_tb
  import asis_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  asis_apb_req_type apb_req = '0;
  asis_apb_rsp_type apb_rsp;
  logic step_req_vld = 1'b0;
  asis_step_type step_req_idx = 3'h0;
  asis_conv_type conv;
  int bad_count = 0;
  int compares = 0;
  int seed = 23772;
  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] keep;
  logic err;
  logic [2:0] last_idx = 3'h0;
  int routed = 0;
  localparam logic [31:0] field_mask = 32'h3333_3333;
  localparam logic [11:0] unmapped_ofs = 12'h008;

  always #2.5 pclk = ~pclk;

  asis_top dut (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .step_req_vld(step_req_vld),
    .step_req_idx(step_req_idx),
    .conv(conv)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [1:0] exp_chan(logic [31:0] v, logic [2:0] i);
    return v[{i, 2'b00} +: 2];
  endfunction

  // Outputs are registered, so values read right after an edge are
  // the ones sampled at the edge before it
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic rerr);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wd;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1);
    // Zero-wait slave: pready stands in the first access cycle
    chk("pready wait", 32'h1, 32'(n));
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // Back-to-back step requests, one per cycle, all eight steps
  task automatic route(input logic [31:0] v);
    logic [2:0] idxs [8];
    logic [2:0] off;
    off = 3'($random(seed));
    for (int j = 0; j < 10; j++) begin
      @(posedge pclk);
      if (j >= 2) begin
        chk("conv vld", 32'h1, {31'h0, conv.vld});
        chk("conv step", {29'h0, idxs[j-2]}, {29'h0, conv.step});
        chk("conv chan", {30'h0, exp_chan(v, idxs[j-2])},
            {30'h0, conv.chan});
      end
      if (j < 8) begin
        idxs[j] = off + 3'(j);
        step_req_vld <= 1'b1;
        step_req_idx <= idxs[j];
      end else begin
        step_req_vld <= 1'b0;
      end
    end
    last_idx = idxs[7];
    routed += 8;
    @(posedge pclk);
    chk("conv vld pulse", 32'h0, {31'h0, conv.vld});
  endtask

  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ASIS_SEL_OFS, 32'h0, rd, err);
    chk("sel reset", 32'h0, rd);
    chk("sel reset err", 32'h0, {31'h0, err});
    $display("test reset done");
    // Corner values first, then random words with gap bits set
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
      apb(1'b1, `ASIS_SEL_OFS, d, rd, err);
      apb(1'b0, `ASIS_SEL_OFS, 32'h0, rd, err);
      chk("sel readback", d & field_mask, rd);
      route(d);
    end
    $display("test write route done");
    // Frozen clock enable: requests are ignored and outputs hold
    @(posedge pclk);
    ce <= 1'b0;
    step_req_vld <= 1'b1;
    step_req_idx <= last_idx + 3'h1;
    repeat (4) @(posedge pclk);
    chk("frozen vld", 32'h0, {31'h0, conv.vld});
    chk("frozen step", {29'h0, last_idx}, {29'h0, conv.step});
    ce <= 1'b1;
    step_req_vld <= 1'b0;
    @(posedge pclk);
    chk("thawed vld", 32'h0, {31'h0, conv.vld});
    // Status: count of routed steps, last step and its channel
    apb(1'b0, `ASIS_STAT_OFS, 32'h0, rd, err);
    chk("stat rd err", 32'h0, {31'h0, err});
    chk("stat word", {16'(routed), 7'h0, 1'b0, 2'h0,
        exp_chan(d, last_idx), 1'b0, last_idx}, rd);
    $display("test freeze done");
    // Unmapped place must error and leave the register alone
    keep = d & field_mask;
    apb(1'b1, unmapped_ofs, ~d, rd, err);
    chk("unmapped wr err", 32'h1, {31'h0, err});
    apb(1'b0, unmapped_ofs, 32'h0, rd, err);
    chk("unmapped rd err", 32'h1, {31'h0, err});
    chk("unmapped rd data", 32'h0, rd);
    apb(1'b1, `ASIS_STAT_OFS, ~d, rd, err);
    chk("status wr err", 32'h0, {31'h0, err});
    apb(1'b0, `ASIS_SEL_OFS, 32'h0, rd, err);
    chk("sel kept", keep, rd);
    $display("test refused done");
    // Read-modify-write of step six keeps every other bit
    d = (rd & ~32'h0030_0000) | 32'h0020_0000;
    apb(1'b1, `ASIS_SEL_OFS, d, rd, err);
    apb(1'b0, `ASIS_SEL_OFS, 32'h0, rd, err);
    chk("sel rmw", d, rd);
    route(d);
    $display("test rmw done");
    // Mid-run reset clears every field and the status count
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    routed = 0;
    apb(1'b0, `ASIS_SEL_OFS, 32'h0, rd, err);
    chk("sel after reset", 32'h0, rd);
    apb(1'b0, `ASIS_STAT_OFS, 32'h0, rd, err);
    chk("stat after reset", 32'h0, rd);
    $display("test mid reset done");
    results();
  end

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    results();
  end
endmodule
